// ### shared/current_cal_pkg.sv
package current_cal_pkg;

    localparam logic [7:0] CMD_PHASE_POS = 8'h37;
    localparam logic [7:0] CMD_GAIN = 8'h38;
    localparam logic [7:0] CMD_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_OV_ACTION = 8'h41;

    localparam logic [7:0] PHASE_LAST = 8'h03;
    localparam logic [7:0] PHASE_ALL = 8'hFF;

    localparam logic [4:0] GAIN_EXP_RST = 5'h19;
    localparam logic [10:0] GAIN_UNITY_MANT = 11'h080;
    localparam int GAIN_FRAC = 10;
    localparam logic signed [31:0] GAIN_MAX_Q10 = 32'sh0000_0800;
    localparam logic signed [31:0] GAIN_NVM_MAX_Q6 = 32'sh0000_007F;

    localparam logic [4:0] OFFSET_EXP_ALL = 5'h1C;
    localparam logic [4:0] OFFSET_EXP_PHASE = 5'h1A;
    localparam int OFFSET_NVM_SHIFT = 6;
    localparam int OFFSET_PHASE_SHIFT = 4;
    localparam int OFFSET_ALL_SHIFT = 6;
    localparam logic signed [31:0] OFF_MIN_Q10 = -32'sh0000_2000;
    localparam logic signed [31:0] OFF_MAX_Q10 = 32'sh0000_1FC0;
    localparam int SENSE_OFFSET_SHIFT = 6;

    localparam logic [23:0] OV_STEP_DEN = 24'h00_0028;
    localparam logic [23:0] OV_BASE_NUM = 24'h00_002A;
    localparam logic [23:0] OV_LIMIT_NUM = 24'h00_0038;
    localparam logic [3:0] OV_TOP_STEP = 4'hE;
    localparam logic [15:0] OV_REL_UNITY = 16'h0200;
    localparam logic [15:0] OV_LIMIT_RST = 16'h0280;

    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_INVALID = 2'h3;
    localparam logic [7:0] OV_ACTION_RST = 8'h80;

    localparam logic [1:0] POR_CATCH = 2'h2;

endpackage : current_cal_pkg

// ### src/current_cal_regs.sv
// Contract
// - Phase position writable only if stand-alone at power-on.
// - Reported current is sensed current times gain, plus the stack offset.
// - Gain trim defaults to one.
// - Gain word: exponent 15:11 resets 11001b, mantissa 10:0.
// - Gain change rescales overcurrent fault and warning thresholds.
// - Out-of-range writes rejected, status flagged, host notified.
// - Restored gain rounds to 1/64, capped 1.984.
// - Offset trim held separately per phase.
// - Stack offset is sum of phase offsets.
// - Offset span -8A to +7.9375A, else rejected.
// - Restore gives supported offset; finer writes accepted.
// - Selector 00h-03h writes and reads one phase.
// - Selector FFh: write divided, read multiplied by count.
// - Overvoltage limit always relative to present target.
// - Overvoltage detection armed once the power-on count completes, three clocks after reset.
// - Converting: round up, 105%-140% in 2.5% steps.
// - Disabled: levels 110%-140% in 10% steps.
// - Overvoltage fault takes the selected response action.
// - Action 00 continue, 01/10 shut down, 11 invalid.
`timescale 1ns/1ns
`default_nettype none

module current_cal_regs
    import current_cal_pkg::*;
#(
    parameter int NUM_PHASES = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdData,
    input wire logic [7:0] phaseSel,
    input wire logic [2:0] stackPhases,
    input wire logic standaloneStrap,
    input wire logic nvmLoad,
    input wire logic [10:0] nvmGainMant,
    input wire logic [10:0] nvmOffsetMant,
    input wire logic clearStatus,
    input wire logic convEnable,
    input wire logic voltFormatAbsolute,
    input wire logic [15:0] voutTarget,
    input wire logic [15:0] voutSense,
    input wire logic [15:0] sensedCurrent,
    input wire logic [15:0] ocFaultBase,
    input wire logic [15:0] ocWarnBase,
    output logic rdValid,
    output logic [15:0] rdData,
    output logic [15:0] reportedCurrent,
    output logic [15:0] ocFaultEff,
    output logic [15:0] ocWarnEff,
    output logic [3:0] ovLevel,
    output logic invalidData,
    output logic ovFault,
    output logic ovShutdown,
    output logic hostAlert,
    output logic phaseWritable
);

    typedef struct packed {
        logic strapMeta;
        logic strapSync;
        logic [1:0] porCnt;
        logic porDone;
        logic standalone;
        logic [7:0] phasePos;
        logic [15:0] gainWord;
        logic [NUM_PHASES-1:0][15:0] offQ10;
        logic [15:0] ovWord;
        logic [7:0] ovAction;
        logic invalidData;
        logic ovFault;
        logic ovShutdown;
        logic hostAlert;
        logic rdValid;
        logic [15:0] rdData;
        logic [15:0] reported;
        logic [15:0] ocFaultEff;
        logic [15:0] ocWarnEff;
        logic [3:0] ovLevel;
    } state_s;

    state_s q;
    state_s d;

    // Linear-11 word to signed fixed point with frac fractional bits; huge exponents saturate.
    function automatic logic signed [31:0] linToFix(input logic [15:0] w, input int frac);
        logic signed [4:0] e;
        logic signed [31:0] m;
        int sh;
        e = signed'(w[15:11]);
        m = 32'(signed'(w[10:0]));
        sh = int'(e) + frac;
        if (sh > 20) begin
            linToFix = 32'sh4000_0000;
        end else if (sh >= 0) begin
            linToFix = m <<< sh;
        end else begin
            linToFix = m >>> (-sh);
        end
    endfunction : linToFix

    function automatic logic signed [31:0] clampOffset(input logic signed [31:0] v);
        if (v < OFF_MIN_Q10) begin
            clampOffset = OFF_MIN_Q10;
        end else if (v > OFF_MAX_Q10) begin
            clampOffset = OFF_MAX_Q10;
        end else begin
            clampOffset = v;
        end
    endfunction : clampOffset

    function automatic logic offsetInSpan(input logic signed [31:0] v);
        offsetInSpan = (v >= OFF_MIN_Q10) && (v <= OFF_MAX_Q10);
    endfunction : offsetInSpan

    // Threshold quantities are held as value*40 against reference*(42+step).
    function automatic logic [23:0] ovScaled(input logic [15:0] refV, input logic [3:0] step);
        ovScaled = 24'(refV) * (OV_BASE_NUM + 24'(step));
    endfunction : ovScaled

    function automatic logic [3:0] ovStepFor(input logic [15:0] value, input logic [15:0] refV,
                                             input logic converting);
        logic [3:0] k;
        k = OV_TOP_STEP;
        for (int i = int'(OV_TOP_STEP); i >= 0; i--) begin
            if (24'(value) * OV_STEP_DEN <= ovScaled(refV, 4'(i))) begin
                k = 4'(i);
            end
        end
        // Disabled output only has every fourth step, so round up to 110/120/130/140.
        ovStepFor = converting ? k : ((k + 4'h1) | 4'h3) - 4'h1;
    endfunction : ovStepFor

    function automatic logic [15:0] scaleByGain(input logic [15:0] v, input logic signed [31:0] g);
        logic signed [47:0] p;
        p = 48'(signed'(v)) * 48'(g);
        scaleByGain = 16'(p >>> GAIN_FRAC);
    endfunction : scaleByGain

    logic signed [31:0] gainQ10;
    logic signed [31:0] wrQ10;
    logic signed [31:0] phaseCount;
    logic signed [31:0] perPhaseQ10;
    logic signed [31:0] offsetSum;
    logic [15:0] ovRef;
    logic [3:0] ovStepNow;
    logic ovTripNow;
    logic [1:0] ovActionSel;
    logic wrNow;
    logic rdNow;
    logic catchNow;

    assign gainQ10 = linToFix(q.gainWord, GAIN_FRAC);
    assign wrQ10 = linToFix(cmdData, GAIN_FRAC);
    assign phaseCount = (stackPhases == 3'h0) ? 32'sh1 : 32'(stackPhases);
    assign perPhaseQ10 = wrQ10 / phaseCount;
    // Relative format is a ratio to unity, absolute is compared with the live target.
    assign ovRef = voltFormatAbsolute ? voutTarget : OV_REL_UNITY;
    assign ovStepNow = ovStepFor(q.ovWord, ovRef, convEnable);
    // The trip point always follows the live target, whatever format the limit is stored in.
    assign ovTripNow = q.porDone && (24'(voutSense) * OV_STEP_DEN > ovScaled(voutTarget, q.ovLevel));
    assign ovActionSel = q.ovAction[7:6];
    assign wrNow = cmdValid && cmdWrite && q.porDone;
    assign rdNow = cmdValid && !cmdWrite && q.porDone;
    assign catchNow = !q.porDone && (q.porCnt == POR_CATCH);

    always_comb begin
        offsetSum = 32'sh0;
        for (int i = 0; i < NUM_PHASES; i++) begin
            if (i < phaseCount) begin
                offsetSum = offsetSum + 32'(signed'(q.offQ10[i]));
            end
        end
    end

    always_comb begin
        logic reject;
        logic signed [31:0] nvmQ6;
        reject = 1'b0;
        nvmQ6 = 32'sh0;
        d = q;
        d.strapMeta = standaloneStrap;
        d.strapSync = q.strapMeta;
        d.rdValid = 1'b0;
        if (!q.porDone) begin
            d.porCnt = q.porCnt + 2'h1;
        end
        if (catchNow) begin
            d.porDone = 1'b1;
            d.standalone = q.strapSync;
        end
        if (catchNow || nvmLoad) begin
            nvmQ6 = (32'(signed'(nvmGainMant)) + 32'sh1) >>> 1;
            if (nvmQ6 > GAIN_NVM_MAX_Q6) begin
                nvmQ6 = GAIN_NVM_MAX_Q6;
            end else if (nvmQ6 < 32'sh0) begin
                nvmQ6 = 32'sh0;
            end
            d.gainWord = {GAIN_EXP_RST, 11'(nvmQ6 <<< 1)};
            for (int i = 0; i < NUM_PHASES; i++) begin
                d.offQ10[i] = 16'(clampOffset(32'(signed'(nvmOffsetMant)) <<< OFFSET_NVM_SHIFT));
            end
        end
        if (wrNow) begin
            case (cmdCode)
                CMD_PHASE_POS: begin
                    if (q.standalone) begin
                        d.phasePos = cmdData[7:0];
                    end else begin
                        reject = 1'b1;
                    end
                end
                CMD_GAIN: begin
                    if (wrQ10 > 32'sh0 && wrQ10 < GAIN_MAX_Q10) begin
                        d.gainWord = cmdData;
                    end else begin
                        reject = 1'b1;
                    end
                end
                CMD_OFFSET: begin
                    if (phaseSel <= PHASE_LAST && offsetInSpan(wrQ10)) begin
                        d.offQ10[phaseSel[1:0]] = 16'(wrQ10);
                    end else if (phaseSel == PHASE_ALL && offsetInSpan(perPhaseQ10)) begin
                        for (int i = 0; i < NUM_PHASES; i++) begin
                            d.offQ10[i] = 16'(perPhaseQ10);
                        end
                    end else begin
                        reject = 1'b1;
                    end
                end
                CMD_OV_LIMIT: begin
                    if (24'(cmdData) * OV_STEP_DEN <= 24'(ovRef) * OV_LIMIT_NUM) begin
                        d.ovWord = cmdData;
                    end else begin
                        reject = 1'b1;
                    end
                end
                CMD_OV_ACTION: begin
                    if (cmdData[7:6] != ACT_INVALID) begin
                        d.ovAction = cmdData[7:0];
                    end else begin
                        reject = 1'b1;
                    end
                end
                default: reject = 1'b0;
            endcase
        end
        if (rdNow) begin
            d.rdValid = 1'b1;
            case (cmdCode)
                CMD_PHASE_POS: d.rdData = {8'h00, q.phasePos};
                CMD_GAIN: d.rdData = q.gainWord;
                CMD_OFFSET: begin
                    if (phaseSel <= PHASE_LAST) begin
                        d.rdData = {OFFSET_EXP_PHASE,
                            11'(32'(signed'(q.offQ10[phaseSel[1:0]])) >>> OFFSET_PHASE_SHIFT)};
                    end else if (phaseSel == PHASE_ALL) begin
                        d.rdData = {OFFSET_EXP_ALL,
                            11'((32'(signed'(q.offQ10[0])) * phaseCount) >>> OFFSET_ALL_SHIFT)};
                    end else begin
                        d.rdData = 16'h0000;
                    end
                end
                CMD_OV_LIMIT: d.rdData = q.ovWord;
                CMD_OV_ACTION: d.rdData = {8'h00, q.ovAction};
                default: d.rdData = 16'h0000;
            endcase
        end
        // A new event wins over a clear arriving in the same cycle.
        d.invalidData = (q.invalidData && !clearStatus) || reject;
        d.ovFault = (q.ovFault && !clearStatus) || ovTripNow;
        // Shutdown holds until the output is commanded off; restarts are sequenced elsewhere.
        if (ovTripNow && ovActionSel != ACT_CONTINUE) begin
            d.ovShutdown = 1'b1;
        end else if (!convEnable) begin
            d.ovShutdown = 1'b0;
        end
        d.hostAlert = d.invalidData || d.ovFault;
        d.ovLevel = ovStepNow;
        d.reported = 16'(32'(signed'(scaleByGain(sensedCurrent, gainQ10)))
            + (offsetSum >>> SENSE_OFFSET_SHIFT));
        d.ocFaultEff = scaleByGain(ocFaultBase, gainQ10);
        d.ocWarnEff = scaleByGain(ocWarnBase, gainQ10);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.gainWord <= {GAIN_EXP_RST, GAIN_UNITY_MANT};
            q.ovWord <= OV_LIMIT_RST;
            q.ovAction <= OV_ACTION_RST;
        end else begin
            q <= d;
        end
    end

    assign rdValid = q.rdValid;
    assign rdData = q.rdData;
    assign reportedCurrent = q.reported;
    assign ocFaultEff = q.ocFaultEff;
    assign ocWarnEff = q.ocWarnEff;
    assign ovLevel = q.ovLevel;
    assign invalidData = q.invalidData;
    assign ovFault = q.ovFault;
    assign ovShutdown = q.ovShutdown;
    assign hostAlert = q.hostAlert;
    assign phaseWritable = q.standalone;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_lockedPhaseWrite;
        wrNow && cmdCode == CMD_PHASE_POS && !q.standalone;
    endsequence
    sequence s_badGainWrite;
        wrNow && cmdCode == CMD_GAIN && !(wrQ10 > 32'sh0 && wrQ10 < GAIN_MAX_Q10);
    endsequence
    sequence s_flagHeld;
        invalidData && hostAlert;
    endsequence

    property p_phase_locked;
        s_lockedPhaseWrite |=> $stable(q.phasePos) && invalidData;
    endproperty
    a_phase_locked: assert property (p_phase_locked) else $error("locked phase write took");
    // A restore in the same cycle legally rewrites the gain, so it is left out here.
    property p_gain_reject;
        s_badGainWrite ##0 !nvmLoad |=> s_flagHeld ##0 $stable(q.gainWord);
    endproperty
    a_gain_reject: assert property (p_gain_reject) else $error("bad gain not rejected");
    property p_gain_rescale;
        $changed(q.gainWord) ##1 $stable(ocFaultBase) |=>
            ocFaultEff == scaleByGain($past(ocFaultBase), $past(gainQ10));
    endproperty
    a_gain_rescale: assert property (p_gain_rescale) else $error("fault limit not rescaled");
    property p_nvm_round;
        nvmLoad && q.porDone && !(wrNow && cmdCode == CMD_GAIN) |=>
            q.gainWord[0] == 1'b0 && q.gainWord[10:8] == 3'h0;
    endproperty
    a_nvm_round: assert property (p_nvm_round) else $error("restored gain not rounded");
    property p_single_phase;
        wrNow && !nvmLoad && cmdCode == CMD_OFFSET && phaseSel == 8'h01 && offsetInSpan(wrQ10)
            |=> $stable(q.offQ10[0]) && q.offQ10[1] == 16'($past(wrQ10));
    endproperty
    a_single_phase: assert property (p_single_phase) else $error("phase write leaked");
    property p_broadcast;
        wrNow && cmdCode == CMD_OFFSET && phaseSel == PHASE_ALL && offsetInSpan(perPhaseQ10)
            && !nvmLoad |=> q.offQ10[0] == q.offQ10[NUM_PHASES-1];
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast offset unequal");
    property p_ov_armed;
        ovTripNow && !convEnable |=> ovFault ##0 hostAlert;
    endproperty
    a_ov_armed: assert property (p_ov_armed) else $error("overvoltage not flagged");
    property p_disabled_levels;
        !convEnable [*2] |-> ovLevel[1:0] == 2'h2;
    endproperty
    a_disabled_levels: assert property (p_disabled_levels) else $error("bad disabled level");
    property p_shutdown;
        ovTripNow && ovActionSel != ACT_CONTINUE |=> ovShutdown;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not taken");

endmodule : current_cal_regs

`default_nettype wire

// ### verification/pmbus_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module pmbus_host_model (
    input wire logic clk_sys,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdData,
    output logic [7:0] phaseSel
);
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdData = 16'h0000;
        phaseSel = 8'h00;
    end

    // One command per strobe; gap adds idle cycles to model a slow host.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] sel,
                        input logic [15:0] data, input int gap);
        repeat (gap) @(negedge clk_sys);
        @(negedge clk_sys);
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdCode = code;
        phaseSel = sel;
        cmdData = data;
        @(negedge clk_sys);
        cmdValid = 1'b0;
        // Released data is inverted so a late sample never sees the old word.
        cmdData = ~data;
    endtask : xfer
endmodule : pmbus_host_model

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    import current_cal_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn, cmdValid, cmdWrite, standaloneStrap, nvmLoad, clearStatus, convEnable;
    logic voltFormatAbsolute, rdValid, invalidData, ovFault, ovShutdown, hostAlert;
    logic phaseWritable;
    logic [7:0] cmdCode, phaseSel;
    logic [2:0] stackPhases;
    logic [10:0] nvmGainMant, nvmOffsetMant;
    logic [15:0] cmdData, voutTarget, voutSense, sensedCurrent, ocFaultBase, ocWarnBase;
    logic [15:0] rdData, reportedCurrent, ocFaultEff, ocWarnEff, s;
    logic [3:0] ovLevel;
    logic [7:0] acts [3] = '{8'h00, 8'h40, 8'h80};
    logic shutExp [3] = '{1'b0, 1'b1, 1'b1};
    int err_total = 0;
    int n_tests = 0;
    logic [15:0] expQ [$];
    string nameQ [$];

    always #25 clk_sys = ~clk_sys;

    pmbus_host_model host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdData(cmdData), .phaseSel(phaseSel));

    current_cal_regs #(.NUM_PHASES(4)) dut (.clk_sys(clk_sys), .resetn(resetn),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
        .phaseSel(phaseSel), .stackPhases(stackPhases), .standaloneStrap(standaloneStrap),
        .nvmLoad(nvmLoad), .nvmGainMant(nvmGainMant), .nvmOffsetMant(nvmOffsetMant),
        .clearStatus(clearStatus), .convEnable(convEnable),
        .voltFormatAbsolute(voltFormatAbsolute), .voutTarget(voutTarget),
        .voutSense(voutSense), .sensedCurrent(sensedCurrent), .ocFaultBase(ocFaultBase),
        .ocWarnBase(ocWarnBase), .rdValid(rdValid), .rdData(rdData),
        .reportedCurrent(reportedCurrent), .ocFaultEff(ocFaultEff), .ocWarnEff(ocWarnEff),
        .ovLevel(ovLevel), .invalidData(invalidData), .ovFault(ovFault),
        .ovShutdown(ovShutdown), .hostAlert(hostAlert), .phaseWritable(phaseWritable));

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic rd(input logic [7:0] code, input logic [7:0] sel, input logic [15:0] exp);
        expQ.push_back(exp);
        nameQ.push_back("rdData");
        host.xfer(1'b0, code, sel, 16'h0000, 0);
    endtask : rd

    task automatic wr(input logic [7:0] code, input logic [7:0] sel, input logic [15:0] d);
        host.xfer(1'b1, code, sel, d, 1);
    endtask : wr

    task automatic clr;
        @(negedge clk_sys);
        clearStatus = 1'b1;
        @(negedge clk_sys);
        clearStatus = 1'b0;
    endtask : clr

    // Flags are sticky, so one extra cycle of settling cannot hide a rejection.
    task automatic flagChk(input logic bad);
        cyc(1);
        cmp("invalidData", {15'h0000, bad}, {15'h0000, invalidData});
        cmp("hostAlert", {15'h0000, bad}, {15'h0000, hostAlert});
        clr();
    endtask : flagChk

    always @(negedge clk_sys) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                cmp("unexpected rdValid", 16'h0000, 16'hFFFF);
            end else begin
                cmp(nameQ.pop_front(), expQ.pop_front(), rdData);
            end
        end
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end

    initial begin
        {resetn, standaloneStrap, nvmLoad, clearStatus, voltFormatAbsolute} = 5'h00;
        convEnable = 1'b1;
        nvmGainMant = 11'h080;
        nvmOffsetMant = 11'h000;
        stackPhases = 3'h4;
        voutTarget = 16'd1000;
        voutSense = 16'd1000;
        sensedCurrent = 16'h0040;
        ocFaultBase = 16'h0100;
        ocWarnBase = 16'h00C0;
        void'($urandom(47));
        cyc(8);
        resetn = 1'b1;
        cyc(6);
        cmp("phaseWritable", 16'h0000, {15'h0000, phaseWritable});
        rd(CMD_GAIN, 8'h00, 16'hC880);
        cmp("ovLevel", 16'h0008, {12'h000, ovLevel});
        wr(CMD_PHASE_POS, 8'h00, 16'h0001);
        flagChk(1'b1);
        wr(CMD_GAIN, 8'h00, 16'hC8C0);
        flagChk(1'b0);
        wr(CMD_GAIN, 8'h00, 16'hC900);
        flagChk(1'b1);
        wr(CMD_GAIN, 8'h00, 16'hCF80);
        flagChk(1'b1);
        rd(CMD_GAIN, 8'h00, 16'hC8C0);
        cmp("ocFaultEff", 16'h0180, ocFaultEff);
        cmp("ocWarnEff", 16'h0120, ocWarnEff);
        wr(CMD_OFFSET, 8'h00, 16'hD040);
        wr(CMD_OFFSET, 8'h01, 16'hD7C0);
        rd(CMD_OFFSET, 8'h00, 16'hD040);
        rd(CMD_OFFSET, 8'h01, 16'hD7C0);
        wr(CMD_OFFSET, 8'h00, 16'hD200);
        flagChk(1'b1);
        wr(CMD_OFFSET, 8'h05, 16'hD040);
        flagChk(1'b1);
        wr(CMD_OFFSET, PHASE_ALL, 16'hE040);
        flagChk(1'b0);
        rd(CMD_OFFSET, PHASE_ALL, 16'hE040);
        rd(CMD_OFFSET, PHASE_LAST, 16'hD040);
        for (int i = 0; i < 4; i++) begin
            s = 16'($urandom_range(0, 127)) * 16'h0002;
            sensedCurrent = s;
            cyc(3);
            cmp("reportedCurrent", s * 16'h0003 / 16'h0002 + 16'h0040, reportedCurrent);
        end
        stackPhases = 3'h2;
        rd(CMD_OFFSET, PHASE_ALL, 16'hE020);
        stackPhases = 3'h4;
        wr(CMD_OV_LIMIT, 8'h00, 16'h0240);
        cyc(3);
        cmp("ovLevel", 16'h0003, {12'h000, ovLevel});
        wr(CMD_OV_LIMIT, 8'h00, 16'h0241);
        cyc(3);
        cmp("ovLevel", 16'h0004, {12'h000, ovLevel});
        convEnable = 1'b0;
        cyc(3);
        cmp("ovLevel", 16'h0006, {12'h000, ovLevel});
        convEnable = 1'b1;
        wr(CMD_OV_LIMIT, 8'h00, 16'h0300);
        flagChk(1'b1);
        rd(CMD_OV_LIMIT, 8'h00, 16'h0241);
        voltFormatAbsolute = 1'b1;
        wr(CMD_OV_LIMIT, 8'h00, 16'd1125);
        cyc(3);
        cmp("ovLevel", 16'h0003, {12'h000, ovLevel});
        voutTarget = 16'd1100;
        cyc(3);
        cmp("ovLevel", 16'h0000, {12'h000, ovLevel});
        rd(CMD_OV_LIMIT, 8'h00, 16'h0465);
        voutTarget = 16'd1000;
        wr(CMD_OV_ACTION, 8'h00, 16'h00C0);
        flagChk(1'b1);
        // Conversion off with no trip, or a reset, is the only way to drop a latched shutdown.
        for (int i = 0; i < 3; i++) begin
            voutSense = 16'd1000;
            convEnable = 1'b0;
            clr();
            cyc(3);
            convEnable = 1'b1;
            wr(CMD_OV_ACTION, 8'h00, {8'h00, acts[i]});
            voutSense = 16'd1130;
            cyc(3);
            cmp("ovFault", 16'h0001, {15'h0000, ovFault});
            cmp("ovShutdown", {15'h0000, shutExp[i]}, {15'h0000, ovShutdown});
        end
        voutSense = 16'd1190;
        convEnable = 1'b0;
        clr();
        cyc(3);
        cmp("ovFault", 16'h0000, {15'h0000, ovFault});
        voutSense = 16'd1210;
        cyc(3);
        cmp("ovFault", 16'h0001, {15'h0000, ovFault});
        voutSense = 16'd1000;
        nvmGainMant = 11'h0FF;
        nvmOffsetMant = 11'h010;
        @(negedge clk_sys);
        nvmLoad = 1'b1;
        @(negedge clk_sys);
        nvmLoad = 1'b0;
        rd(CMD_GAIN, 8'h00, 16'hC8FE);
        rd(CMD_OFFSET, 8'h02, 16'hD040);
        // A second power-on with the strap high must unlock the phase position.
        cyc(2);
        convEnable = 1'b1;
        standaloneStrap = 1'b1;
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(6);
        cmp("phaseWritable", 16'h0001, {15'h0000, phaseWritable});
        rd(CMD_GAIN, 8'h00, 16'hC8FE);
        wr(CMD_PHASE_POS, 8'h00, 16'h0002);
        flagChk(1'b0);
        rd(CMD_PHASE_POS, 8'h00, 16'h0002);
        for (int k = 0; k < 20 && expQ.size() > 0; k++) begin
            cyc(1);
        end
        if (expQ.size() > 0) begin
            err_total++;
        end
        give_verdict();
    end
endmodule : tb

`default_nettype wire
